// ===== uartms_pkg.sv
// Constants and register map of the serial port with modem handshake.
package uartms_pkg;
    // Byte addresses on the APB bus, one word per register.
    localparam logic [7:0] ADDR_TXD = 8'h00;
    localparam logic [7:0] ADDR_IER = 8'h04;
    localparam logic [7:0] ADDR_MCR = 8'h10;
    localparam logic [7:0] ADDR_LSR = 8'h14;
    localparam logic [7:0] ADDR_MSR = 8'h18;
    localparam logic [7:0] ADDR_SCR = 8'h1C;
    localparam logic [7:0] ADDR_DIV = 8'h20;

    // Status register field positions.
    localparam int MSR_DCTS = 0;
    localparam int MSR_DDSR = 1;
    localparam int MSR_DRI = 2;
    localparam int MSR_DDCD = 3;
    localparam int MSR_CTS = 4;
    localparam int MSR_DSR = 5;
    localparam int MSR_RI = 6;
    localparam int MSR_DCD = 7;

    // Control, enable and line status field positions.
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int IER_MSI = 3;
    localparam int LSR_FULL = 0;
    localparam int LSR_THRE = 5;
    localparam int LSR_TEMT = 6;

    // Reset values.
    localparam logic [7:0] MCR_RESET = 8'h00;
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [15:0] DIV_RESET = 16'h000C;
    localparam logic [3:0] MODEM_IDLE = 4'h0;

    // Transmit FIFO geometry.
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    localparam logic [4:0] FIFO_FULL_CNT = 5'h10;

    // Timing: reference clock stepped out of the bus clock.
    localparam int PCLK_HZ = 50000000;
    localparam int REF_CLK_HZ = 1846200;
    localparam int MAX_BAUD = 56000;
    localparam int REF_STEP = REF_CLK_HZ / 100;
    localparam int REF_MOD = PCLK_HZ / 100;
    localparam logic [19:0] REF_STEP_W = 20'(REF_STEP);
    localparam logic [19:0] REF_MOD_W = 20'(REF_MOD);
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam logic [2:0] DATA_BITS_LAST = 3'h7;

    // Serializer states.
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } uartms_tx_state_t;
endpackage

// ===== uartms_skid.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module uartms_skid (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data
);
    logic [7:0] mem [2];
    logic wr_reg;
    logic rd_reg;
    logic [1:0] cnt_reg;
    logic push;
    logic pop;

    // Full and empty come straight from the count, so neither can lie.
    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data = mem[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage holds no reset; only the pointers and the count need a defined state.
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push) begin
                wr_reg <= ~wr_reg;
            end
            if (pop) begin
                rd_reg <= ~rd_reg;
            end
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ===== uartms_txser.sv
// Transmit serializer: start bit, eight data bits LSB first, stop bit.
`timescale 1ns/100ps
module uartms_txser
    import uartms_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Sixteen-times bit rate strobe.
    input wire logic tick16,
    // Character input.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    // Line and status.
    output logic txd,
    output logic busy
);
    uartms_tx_state_t state_reg;
    logic [3:0] sub_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    logic bit_end;

    // A character is only taken while the line is idle.
    assign in_ready = (state_reg == TX_IDLE);
    assign busy = (state_reg != TX_IDLE);
    assign bit_end = tick16 && (sub_reg == OVERSAMPLE_LAST);

    // Frame sequencing; each bit lasts sixteen strobes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= TX_IDLE;
            sub_reg <= 4'h0;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
        end else begin
            if (tick16 && state_reg != TX_IDLE) begin
                sub_reg <= sub_reg + 4'h1;
            end
            case (state_reg)
                TX_IDLE: begin
                    sub_reg <= 4'h0;
                    if (in_valid) begin
                        shift_reg <= in_data;
                        state_reg <= TX_START;
                    end
                end
                TX_START: begin
                    if (bit_end) begin
                        bit_reg <= 3'h0;
                        state_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (bit_end) begin
                        shift_reg <= {1'b0, shift_reg[7:1]};
                        bit_reg <= bit_reg + 3'h1;
                        if (bit_reg == DATA_BITS_LAST) begin
                            state_reg <= TX_STOP;
                        end
                    end
                end
                TX_STOP: begin
                    if (bit_end) begin
                        state_reg <= TX_IDLE;
                    end
                end
                default: begin
                    state_reg <= TX_IDLE;
                end
            endcase
        end
    end

    // Line level registered so the pin never glitches.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd <= 1'b1;
        end else begin
            case (state_reg)
                TX_START: txd <= 1'b0;
                TX_DATA: txd <= shift_reg[0];
                default: txd <= 1'b1;
            endcase
        end
    end
endmodule

// ===== uartms_top.sv
// Serial port top: APB registers, modem handshake, FIFO and baud timing.
`timescale 1ns/100ps
module uartms_top
    import uartms_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Modem inputs, all active low.
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic dcd_n,
    input wire logic ri_n,
    // Modem outputs, active low.
    output logic dtr_n,
    output logic rts_n,
    // Serial data out.
    output logic txd,
    // Interrupt jumper and modem interrupt request.
    input wire logic irq_jumper,
    output logic irq
);
    // Address match, shared by read and write decoding.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    logic setup;
    logic access;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic [7:0] ier_reg;
    logic [7:0] mcr_reg;
    logic [7:0] scr_reg;
    logic [15:0] div_reg;
    logic [3:0] lvl_reg;
    logic [3:0] lvl_now;
    logic [3:0] chg;
    logic [3:0] delta_reg;
    logic [3:0] delta_next;
    logic [3:0] snap_reg;
    logic [7:0] msr_view;
    logic [7:0] lsr_view;
    logic [31:0] rd_mux;
    logic [7:0] fifo_mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] fwr_reg;
    logic [FIFO_AW-1:0] frd_reg;
    logic [4:0] fcnt_reg;
    logic fpush;
    logic fpop;
    logic skid_ready;
    logic skid_valid;
    logic [7:0] skid_data;
    logic ser_ready;
    logic ser_busy;
    logic [19:0] acc_reg;
    logic [19:0] acc_sum;
    logic ref_tick;
    logic [15:0] pre_reg;
    logic [15:0] div_last;
    logic tick16;
    logic mcr_wr;

    // Every check below runs on the bus clock and sleeps during reset.
    default clocking cb_chk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // APB phases; the slave never waits, so every access ends at once.
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = 1'b1;
    assign wr_acc = access && pwrite;
    assign rd_acc = access && !pwrite;
    assign mapped = hit(paddr, ADDR_TXD) || hit(paddr, ADDR_IER)
        || hit(paddr, ADDR_MCR) || hit(paddr, ADDR_LSR)
        || hit(paddr, ADDR_MSR) || hit(paddr, ADDR_SCR)
        || hit(paddr, ADDR_DIV);
    assign pslverr = access && !mapped;

    // Present levels in positive sense: a low pin reads as one.
    // Index order is CTS, DSR, RI, DCD to match the change field.
    assign lvl_now = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
    assign chg = lvl_now ^ lvl_reg;

    // Level capture; inputs are taken as synchronous already.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_reg <= MODEM_IDLE;
        end else begin
            lvl_reg <= lvl_now;
        end
    end

    // Change flags: only bits shown by the read are cleared, and a
    // fresh change in the same cycle wins over the clear.
    always_comb begin
        delta_next = delta_reg;
        if (rd_acc && hit(paddr, ADDR_MSR)) begin
            delta_next = delta_reg & ~snap_reg;
        end
        delta_next = delta_next | chg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delta_reg <= MODEM_IDLE;
        end else begin
            delta_reg <= delta_next;
        end
    end

    // Status as software sees it; the data-set-ready level is the
    // modem's own statement that it is ready to start.
    assign msr_view = {lvl_reg[3], lvl_reg[2], lvl_reg[1], lvl_reg[0],
        delta_reg[3], delta_reg[2], delta_reg[1], delta_reg[0]};
    assign lsr_view = {1'b0,
        (fcnt_reg == 5'h00) && !skid_valid && !ser_busy,
        (fcnt_reg == 5'h00), 4'h0, (fcnt_reg == FIFO_FULL_CNT)};

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            ADDR_IER: rd_mux = {24'h00_0000, ier_reg};
            ADDR_MCR: rd_mux = {24'h00_0000, mcr_reg};
            ADDR_LSR: rd_mux = {24'h00_0000, lsr_view};
            ADDR_MSR: rd_mux = {24'h00_0000, msr_view};
            ADDR_SCR: rd_mux = {24'h00_0000, scr_reg};
            ADDR_DIV: rd_mux = {16'h0000, div_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is caught in the setup cycle so it comes from a flop;
    // the snapshot remembers which change flags software has seen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            snap_reg <= MODEM_IDLE;
        end else if (setup && !pwrite) begin
            prdata <= rd_mux;
            snap_reg <= delta_reg;
        end
    end

    // Software-written registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ier_reg <= IER_RESET;
            mcr_reg <= MCR_RESET;
            scr_reg <= 8'h00;
            div_reg <= DIV_RESET;
        end else if (wr_acc) begin
            if (hit(paddr, ADDR_IER)) begin
                ier_reg <= pwdata[7:0];
            end
            if (hit(paddr, ADDR_MCR)) begin
                mcr_reg <= pwdata[7:0];
            end
            if (hit(paddr, ADDR_SCR)) begin
                scr_reg <= pwdata[7:0];
            end
            if (hit(paddr, ADDR_DIV)) begin
                div_reg <= pwdata[15:0];
            end
        end
    end

    // Modem outputs and interrupt are registered so the pins are clean.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dtr_n <= 1'b1;
            rts_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            dtr_n <= ~mcr_reg[MCR_DTR];
            rts_n <= ~mcr_reg[MCR_RTS];
            irq <= irq_jumper && ier_reg[IER_MSI]
                && (|delta_reg);
        end
    end

    // Transmit FIFO; a write while full is dropped, which software
    // avoids by watching the full bit in line status.
    assign fpush = wr_acc && hit(paddr, ADDR_TXD)
        && (fcnt_reg != FIFO_FULL_CNT);
    assign fpop = (fcnt_reg != 5'h00) && skid_ready;

    always_ff @(posedge pclk) begin
        if (fpush) begin
            fifo_mem[fwr_reg] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwr_reg <= '0;
            frd_reg <= '0;
            fcnt_reg <= 5'h00;
        end else begin
            if (fpush) begin
                fwr_reg <= fwr_reg + 1'b1;
            end
            if (fpop) begin
                frd_reg <= frd_reg + 1'b1;
            end
            fcnt_reg <= fcnt_reg + {4'h0, fpush} - {4'h0, fpop};
        end
    end

    // The buffer absorbs a stall by the serializer without a loss.
    uartms_skid u_skid (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(fcnt_reg != 5'h00),
        .in_ready(skid_ready),
        .in_data(fifo_mem[frd_reg]),
        .out_valid(skid_valid),
        .out_ready(ser_ready),
        .out_data(skid_data)
    );

    // Reference clock made by a fractional accumulator; its jitter is
    // one bus clock, small against a sixteenth of a bit.
    assign acc_sum = acc_reg + REF_STEP_W;
    assign ref_tick = (acc_sum >= REF_MOD_W);
    assign div_last = (div_reg == 16'h0000) ? 16'h0000 : div_reg - 16'h0001;
    assign tick16 = ref_tick && (pre_reg >= div_last);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= 20'h00000;
            pre_reg <= 16'h0000;
        end else begin
            acc_reg <= ref_tick ? acc_sum - REF_MOD_W : acc_sum;
            if (tick16) begin
                pre_reg <= 16'h0000;
            end else if (ref_tick) begin
                pre_reg <= pre_reg + 16'h0001;
            end
        end
    end

    uartms_txser u_txser (
        .pclk(pclk),
        .presetn(presetn),
        .tick16(tick16),
        .in_valid(skid_valid),
        .in_ready(ser_ready),
        .in_data(skid_data),
        .txd(txd),
        .busy(ser_busy)
    );

    // Checks. A control write, named once for the pin checks below.
    assign mcr_wr = wr_acc && hit(paddr, ADDR_MCR);

    sequence s_msr_setup;
        setup && !pwrite && hit(paddr, ADDR_MSR) && !(|chg);
    endsequence
    sequence s_msr_access;
        rd_acc && hit(paddr, ADDR_MSR) && !(|chg);
    endsequence

    AST_CTS_LEVEL: assert property (
        ##1 msr_view[MSR_CTS] == !$past(cts_n))
        else $error("CTS level bit wrong");
    AST_CTS_DELTA: assert property (
        $changed(cts_n) ##1 $stable(cts_n) |-> msr_view[MSR_DCTS])
        else $error("CTS change not flagged");
    AST_READ_CLEARS: assert property (
        s_msr_setup ##1 s_msr_access |=> (delta_reg == MODEM_IDLE))
        else $error("Status read did not clear change flags");
    AST_CTS_IRQ: assert property (
        (irq_jumper && ier_reg[IER_MSI] && (chg[0]))
        ##1 (irq_jumper && ier_reg[IER_MSI]) |=> irq)
        else $error("No interrupt on CTS change");
    AST_DSR_DELTA: assert property (
        chg[1] |=> msr_view[MSR_DDSR] && msr_view[MSR_DSR] == !$past(dsr_n))
        else $error("DSR change not flagged");
    AST_DCD_DELTA: assert property (
        chg[3] |=> msr_view[MSR_DDCD] && msr_view[MSR_DCD] == !$past(dcd_n))
        else $error("DCD change not flagged");
    AST_RI_DELTA: assert property (
        chg[2] |=> msr_view[MSR_DRI] && msr_view[MSR_RI] == !$past(ri_n))
        else $error("Ring change not flagged");
    AST_NO_IRQ_MASKED: assert property (
        !irq_jumper |=> !irq)
        else $error("Interrupt without jumper");
    AST_DTR_WRITE: assert property (
        mcr_wr |=> ##1 dtr_n == !$past(pwdata[0], 2))
        else $error("DTR does not follow control bit");
    AST_RTS_WRITE: assert property (
        mcr_wr |=> ##1 rts_n == !$past(pwdata[1], 2))
        else $error("RTS does not follow control bit");
    AST_FIFO_BOUND: assert property (
        fcnt_reg == FIFO_FULL_CNT && !fpop |=> fcnt_reg == FIFO_FULL_CNT)
        else $error("FIFO count overran");
    AST_TX_IDLE: assert property (
        !ser_busy [*2] |-> txd)
        else $error("Line not idle high");

    // The pins move only two edges after a control write, never alone.
    AST_DTR_HOLD: assert property (
        !mcr_wr |-> ##2 $stable(dtr_n))
        else $error("DTR moved without a control write");
    AST_RTS_HOLD: assert property (
        !mcr_wr |-> ##2 $stable(rts_n))
        else $error("RTS moved without a control write");
    AST_MSR_READ_DATA: assert property (
        setup && !pwrite && hit(paddr, ADDR_MSR)
        |=> prdata == {24'h00_0000, $past(msr_view)})
        else $error("Status read data wrong");
    AST_IRQ_DISABLED: assert property (
        !ier_reg[IER_MSI] |=> !irq)
        else $error("Interrupt while disabled");
    // A write with room and no drain must grow the count by one.
    AST_FIFO_PUSH: assert property (
        wr_acc && hit(paddr, ADDR_TXD) && (fcnt_reg < FIFO_FULL_CNT)
        && !fpop |=> fcnt_reg == $past(fcnt_reg) + 5'h01)
        else $error("FIFO did not take a character");
endmodule

// ===== umcs_modem.sv
// Behavioural modem: drives the handshake inputs and decodes the serial line.
`timescale 1ns/100ps
module umcs_modem (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Asserted levels wanted: 0 cts, 1 dsr, 2 ri, 3 dcd.
    input wire logic [3:0] assert_req,
    // Handshake outputs, active low.
    output logic cts_n,
    output logic dsr_n,
    output logic dcd_n,
    output logic ri_n,
    // Serial line and decoded characters.
    input wire logic txd,
    output logic [7:0] rx_byte,
    output logic [7:0] rx_count
);
    // One bit is 16 reference ticks of about 27.08 bus clocks each.
    localparam int BIT_CLKS = 433;
    int cnt;
    int bitn;
    logic busy;
    logic [7:0] shreg;

    // Pins follow the request one edge later, as a real modem lags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {dcd_n, ri_n, dsr_n, cts_n} <= 4'hF;
        end else begin
            {dcd_n, ri_n, dsr_n, cts_n} <= ~assert_req;
        end
    end

    // Mid-bit sampler; drift over ten bits stays well inside half a bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'h0;
            cnt <= 0;
            bitn <= 0;
            shreg <= 8'h00;
            rx_byte <= 8'h00;
            rx_count <= 8'h00;
        end else if (!busy) begin
            if (!txd) begin
                busy <= 1'h1;
                cnt <= BIT_CLKS / 2;
                bitn <= 0;
            end
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            cnt <= BIT_CLKS - 1;
            bitn <= bitn + 1;
            if (bitn == 0 && txd) begin
                busy <= 1'h0;
            end
            if (bitn >= 1 && bitn <= 8) begin
                shreg <= {txd, shreg[7:1]};
            end
            if (bitn == 9) begin
                busy <= 1'h0;
                rx_byte <= shreg;
                rx_count <= rx_count + 8'h01;
            end
        end
    end
endmodule

// ===== test_uart_modem_control_status.sv
// Self-checking bench for the serial port modem handshake block.
`timescale 1ns/100ps
module test_uart_modem_control_status;
    import uartms_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, irq_jumper, err;
    logic [7:0] paddr, rx_byte, rx_count;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, dtr_n, rts_n, txd, irq;
    logic cts_n, dsr_n, dcd_n, ri_n;
    logic [3:0] req;
    int mismatches, n_tests;

    uartms_top uartms_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n(cts_n),
        .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n), .dtr_n(dtr_n),
        .rts_n(rts_n), .txd(txd), .irq_jumper(irq_jumper), .irq(irq));
    umcs_modem umcs_modem_i (.pclk(pclk), .presetn(presetn),
        .assert_req(req), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n),
        .ri_n(ri_n), .txd(txd), .rx_byte(rx_byte), .rx_count(rx_count));

    // Bus clock, 20 ns period.
    initial begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic give_up();
        $display("ERROR at %0t: wait ran out", $time);
        mismatches++;
        results();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        if (k >= 50) begin
            give_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        check(rd, e);
    endtask

    // Reset values, scratch access and an unmapped address.
    task automatic t_reset();
        check(dtr_n, 1'h1);
        check(rts_n, 1'h1);
        check(txd, 1'h1);
        check(irq, 1'h0);
        rdchk(ADDR_MCR, 32'h0);
        rdchk(ADDR_MSR, 32'h0);
        rdchk(ADDR_DIV, 32'h0000000C);
        rdchk(ADDR_LSR, 32'h60);
        apb(1'h1, ADDR_SCR, 32'h5A);
        rdchk(ADDR_SCR, 32'h5A);
        apb(1'h0, 8'h3C, 32'h0);
        check(err, 1'h1);
        check(rd, 32'h0);
        $display("reset test done");
    endtask

    // Every control code reaches both outputs, inverted.
    task automatic t_mcr();
        for (int v = 0; v < 4; v++) begin
            apb(1'h1, ADDR_MCR, 32'(v));
            cyc(3);
            check(dtr_n, !v[0]);
            check(rts_n, !v[1]);
            rdchk(ADDR_MCR, 32'(v));
        end
        $display("control test done");
    endtask

    // Each input in turn: level plus change flag, then flag cleared by read.
    task automatic t_msr();
        logic [7:0] lv;
        lv = 8'h00;
        for (int i = 0; i < 4; i++) begin
            req[i] <= 1'h1;
            cyc(4);
            lv[4 + i] = 1'h1;
            lv[i] = 1'h1;
            rdchk(ADDR_MSR, {24'h0, lv});
            lv[i] = 1'h0;
            rdchk(ADDR_MSR, {24'h0, lv});
        end
        req <= 4'h0;
        cyc(4);
        rdchk(ADDR_MSR, 32'h0F);
        rdchk(ADDR_MSR, 32'h00);
        $display("status test done");
    endtask

    // Interrupt gated by jumper and enable, cleared by a status read.
    task automatic t_irq();
        apb(1'h1, ADDR_IER, 32'h08);
        irq_jumper <= 1'h1;
        req[0] <= 1'h1;
        cyc(5);
        check(irq, 1'h1);
        apb(1'h0, ADDR_MSR, 32'h0);
        cyc(3);
        check(irq, 1'h0);
        irq_jumper <= 1'h0;
        req[1] <= 1'h1;
        cyc(5);
        check(irq, 1'h0);
        irq_jumper <= 1'h1;
        cyc(3);
        check(irq, 1'h1);
        apb(1'h1, ADDR_IER, 32'h0);
        cyc(3);
        check(irq, 1'h0);
        req <= 4'h0;
        cyc(4);
        apb(1'h0, ADDR_MSR, 32'h0);
        $display("interrupt test done");
    endtask

    task automatic wait_rx(input logic [7:0] n);
        int k;
        k = 0;
        while (rx_count !== n && k < 8000) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 8000) begin
            give_up();
        end
    endtask

    // Two characters back to back at the fastest divisor.
    task automatic t_tx();
        logic [7:0] data [2];
        data[0] = 8'hA5;
        data[1] = 8'h3C;
        apb(1'h1, ADDR_DIV, 32'h1);
        for (int i = 0; i < 2; i++) begin
            apb(1'h1, ADDR_TXD, {24'h0, data[i]});
        end
        for (int i = 0; i < 2; i++) begin
            wait_rx(8'(i + 1));
            check(rx_byte, data[i]);
        end
        cyc(400);
        rdchk(ADDR_LSR, 32'h60);
        $display("transmit test done");
    endtask

    // Sixteen FIFO slots, two buffer slots and the shifter fill up.
    task automatic t_fill();
        for (int i = 0; i < 20; i++) begin
            apb(1'h1, ADDR_TXD, 32'(i));
        end
        apb(1'h0, ADDR_LSR, 32'h0);
        check(rd[LSR_FULL], 1'h1);
        check(rd[LSR_THRE], 1'h0);
        $display("fill test done");
    endtask

    // Main sequence: reset held ten cycles, then each scenario.
    initial begin
        mismatches = 0;
        n_tests = 0;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        req = 4'h0;
        irq_jumper = 1'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_mcr();
        t_msr();
        t_irq();
        t_tx();
        t_fill();
        results();
    end
endmodule
